/* core/fes_pkg.sv */
// package for the flash erase/program sequencer
// assumes one 100 MHz clock domain; bus cycles come from an enable divider
package fes_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int SPD_W = 8;
  localparam int ROW_BYTES = 32;
  localparam int PAGE_BYTES = 64;
  localparam logic [ADDR_W-1:0] ROW_MASK = 16'hffe0;
  localparam logic [ADDR_W-1:0] PAGE_MASK = 16'hffc0;
  localparam logic [ADDR_W-1:0] BPR_ADDR = 16'hff7e;
  localparam logic [ADDR_W-1:0] FLASH_BASE = 16'hc000;
  localparam logic [ADDR_W-1:0] FLASH_TOP = 16'hfdff;
  // bus clock divider: 100 MHz system clock, bus enable every N cycles
  localparam int CLK_MHZ = 100;
  localparam logic [7:0] BUS_DIV = 8'h19;
  localparam int BUS_MHZ_X4 = (CLK_MHZ * 4) / 25;
  // erase window in microseconds; target set inside 4 ms .. 5.5 ms
  localparam int ERASE_MIN_US = 4000;
  localparam int ERASE_MAX_US = 5500;
  localparam int ERASE_TGT_US = 4500;
  // erase loop: cycles per quarter-microsecond-per-speed unit
  localparam logic [31:0] ERASE_UNITS = 32'(ERASE_TGT_US);
  localparam logic [SPD_W-1:0] SPD_MIN = 8'h04;
  localparam logic [SPD_W-1:0] SPD_MAX = 8'h20;
  localparam logic [SPD_W-1:0] SPD_ROW_MIN = 8'h05;
  localparam logic [15:0] PROG_CASE1_CYC = 16'h0026;
  localparam logic [15:0] WD_BASE = 16'h0033;
  localparam logic [15:0] WD_MUL = 16'h0003;
  localparam logic [15:0] PROG_MUL = 16'h0008;
  localparam logic [15:0] PROG_ADD = 16'h0005;
  // watchdog reserviced every this many bus cycles after the first one
  localparam logic [15:0] WD_PERIOD = 16'h0400;
endpackage

/* core/fes_pulse_timer.sv */
// programmable down counter that times one pulse in bus cycles
// assumes i_bus_en is a one-cycle enable on the same clock
`timescale 1ns/100ps
module fes_pulse_timer (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_bus_en,
  input wire logic i_load,
  input wire logic [31:0] i_count,
  output logic o_busy,
  output logic o_done
);
  typedef struct packed {
    logic [31:0] cnt;
    logic busy;
    logic done;
  } fes_tmr_type;
  fes_tmr_type s_reg, s_next;
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (i_load) begin
      s_next.cnt = i_count;
      s_next.busy = 1'b1;
    end else if (s_reg.busy && i_bus_en) begin
      if (s_reg.cnt <= 32'h1) begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
        s_next.cnt = 32'h0;
      end else begin
        s_next.cnt = s_reg.cnt - 32'h1;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign o_busy = s_reg.busy;
  assign o_done = s_reg.done;
endmodule

/* core/fes_sequencer.sv */
// flash erase / range-program sequencer with pulse timing and watchdog
// assumes flash array write port and protect value on the same clock;
// the high-voltage test detect and monitor security flag are pins
//
// Behaviour
// (RULE1) after a range program the address pair points past the last byte.
// (RULE2) program accepts ranges from one byte up to a row, start to last.
// (RULE3) erase clears one 64-byte page or the whole array.
// (RULE4) an address equal to the protect register selects a whole erase.
// (RULE5) any other flash address erases only its containing page.
// (RULE6) timing scales with the speed code over the 1 to 8 MHz range.
// (RULE7) each erase pulse lasts between 4 ms and 5.5 ms.
// (RULE8) the caller loads the speed code as four times the MHz rate.
// (RULE9) interrupts are masked during erase and restored at the end.
// (RULE10) first watchdog service comes 51 plus 3 times speed code cycles in.
// (RULE11) the caller gives a page address or the protect register address.
// (RULE12) protected locations are not erased.
// (RULE13) test high voltage on the interrupt pin bypasses protection.
// (RULE14) a completed whole erase re-opens access after a failed check.
// (RULE15) the caller keeps one program request inside one row.
// (RULE16) from speed code five up each program pulse is 8 x code + 5 cycles.
// (RULE17) the watchdog is serviced periodically through the erase pulse.
`timescale 1ns/100ps
module fes_sequencer (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_erase_start,
  input wire logic i_prog_start,
  input wire logic [fes_pkg::ADDR_W-1:0] i_index_addr,
  input wire logic [fes_pkg::ADDR_W-1:0] i_last_range_address,
  input wire logic [fes_pkg::SPD_W-1:0] i_op_speed_code,
  input wire logic [fes_pkg::DATA_W-1:0] i_prog_data,
  input wire logic [fes_pkg::DATA_W-1:0] i_block_protect_reg,
  input wire logic i_irq_mask,
  input wire logic i_hv_test,
  input wire logic i_sec_failed,
  output logic o_busy,
  output logic o_done,
  output logic [fes_pkg::ADDR_W-1:0] o_index_addr,
  output logic o_irq_mask,
  output logic o_watchdog_service,
  output logic o_data_req,
  output logic o_flash_we,
  output logic o_flash_hv,
  output logic o_page_erase,
  output logic o_array_erase,
  output logic [fes_pkg::ADDR_W-1:0] o_flash_addr,
  output logic [fes_pkg::DATA_W-1:0] o_flash_data,
  output logic o_erase_refused,
  output logic o_access_ok
);
  import fes_pkg::*;

  // ****************************************************************
  // state and pin synchronisers
  // ****************************************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_EWAIT = 6'b000010,
    ST_EPULSE = 6'b000100,
    ST_PLOAD = 6'b001000,
    ST_PPULSE = 6'b010000,
    ST_FIN = 6'b100000
  } fes_state_type;

  typedef struct packed {
    fes_state_type st;
    logic [7:0] div;
    logic bus_en;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] last;
    logic [SPD_W-1:0] spd;
    logic saved_mask;
    logic mask;
    logic [15:0] wd_cnt;
    logic wd_first;
    logic wd_pulse;
    logic whole;
    logic done;
    logic we;
    logic hv;
    logic [DATA_W-1:0] data;
    logic refused;
    logic access_ok;
    logic [1:0] hv_sync;
    logic [1:0] sec_sync;
    logic sec_q;
  } fes_seq_type;

  fes_seq_type s_reg, s_next;
  logic tmr_load, tmr_busy, tmr_done;
  logic [31:0] tmr_count;
  logic [ADDR_W-1:0] prot_base;
  logic is_prot;
  logic [31:0] erase_cyc;
  logic [15:0] prog_cyc;

  fes_pulse_timer u_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_bus_en(s_reg.bus_en),
    .i_load(tmr_load),
    .i_count(tmr_count),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  // ****************************************************************
  // pulse lengths
  // ****************************************************************
  // protect value selects the lowest protected address in 64-byte steps
  assign prot_base = {2'b11, i_block_protect_reg, 6'h00};
  // erase time scales with speed code: code/4 cycles per microsecond
  assign erase_cyc = (ERASE_UNITS * 32'(s_reg.spd)) >> 2; // RULE6 RULE7
  assign prog_cyc = (s_reg.spd < SPD_ROW_MIN) ? PROG_CASE1_CYC :
    16'(PROG_MUL * 16'(s_reg.spd) + PROG_ADD); // RULE16

  always_comb begin
    is_prot = 1'b0;
    if (i_block_protect_reg != 8'hff) begin
      is_prot = s_reg.whole || (s_reg.addr >= prot_base); // RULE12
    end
    if (s_reg.hv_sync[1]) begin
      is_prot = 1'b0; // RULE13
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    tmr_load = 1'b0;
    tmr_count = 32'h0;
    s_next.hv_sync = {s_reg.hv_sync[0], i_hv_test};
    s_next.sec_sync = {s_reg.sec_sync[0], i_sec_failed};
    s_next.done = 1'b0;
    s_next.wd_pulse = 1'b0;
    s_next.we = 1'b0;
    s_next.bus_en = 1'b0;
    if (s_reg.div >= BUS_DIV - 8'h1) begin
      s_next.div = 8'h0;
      s_next.bus_en = 1'b1;
    end else begin
      s_next.div = s_reg.div + 8'h1;
    end
    s_next.sec_q = s_reg.sec_sync[1];
    // a failed check closes access on its rising edge only, so a pin
    // left high cannot undo a later whole erase; that erase wins below
    if (s_reg.sec_sync[1] && !s_reg.sec_q) begin
      s_next.access_ok = 1'b0; // RULE14
    end
    if (s_reg.st != ST_IDLE && s_reg.bus_en) begin
      if (s_reg.wd_cnt <= 16'h1) begin
        s_next.wd_pulse = 1'b1; // RULE10
        s_next.wd_cnt = WD_PERIOD; // RULE17
      end else begin
        s_next.wd_cnt = s_reg.wd_cnt - 16'h1;
      end
    end
    unique case (s_reg.st)
      ST_IDLE: begin
        s_next.refused = 1'b0;
        if (i_erase_start) begin
          s_next.saved_mask = i_irq_mask;
          s_next.mask = 1'b1; // RULE9
          s_next.spd = i_op_speed_code; // RULE8
          s_next.whole = (i_index_addr == BPR_ADDR); // RULE4 RULE11
          s_next.addr = (i_index_addr == BPR_ADDR) ? FLASH_BASE :
            (i_index_addr & PAGE_MASK); // RULE3 RULE5
          s_next.wd_cnt = 16'(WD_BASE + WD_MUL * 16'(i_op_speed_code));
          s_next.st = ST_EWAIT;
        end else if (i_prog_start) begin
          s_next.saved_mask = i_irq_mask;
          s_next.mask = 1'b1;
          s_next.spd = i_op_speed_code;
          s_next.addr = i_index_addr;
          s_next.last = i_last_range_address; // RULE2 RULE15
          s_next.wd_cnt = WD_PERIOD;
          s_next.st = ST_PLOAD;
        end
      end
      ST_EWAIT: begin
        if (is_prot) begin
          s_next.refused = 1'b1; // RULE12
          s_next.st = ST_FIN;
        end else begin
          tmr_load = 1'b1;
          tmr_count = erase_cyc;
          s_next.hv = 1'b1;
          s_next.st = ST_EPULSE;
        end
      end
      ST_EPULSE: begin
        if (tmr_done) begin
          s_next.hv = 1'b0;
          if (s_reg.whole) begin
            s_next.access_ok = 1'b1; // RULE14
          end
          s_next.st = ST_FIN;
        end
      end
      ST_PLOAD: begin
        s_next.data = i_prog_data;
        s_next.we = 1'b1;
        s_next.hv = 1'b1;
        tmr_load = 1'b1;
        tmr_count = 32'(prog_cyc);
        s_next.st = ST_PPULSE;
      end
      ST_PPULSE: begin
        if (tmr_done) begin
          s_next.hv = 1'b0;
          s_next.addr = s_reg.addr + 16'h1; // RULE1
          if (s_reg.addr == s_reg.last) begin
            s_next.st = ST_FIN;
          end else begin
            s_next.st = ST_PLOAD;
          end
        end
      end
      ST_FIN: begin
        s_next.mask = s_reg.saved_mask; // RULE9
        s_next.done = 1'b1;
        s_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.access_ok <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_busy = (s_reg.st != ST_IDLE);
  assign o_done = s_reg.done;
  assign o_index_addr = s_reg.addr;
  assign o_irq_mask = s_reg.mask;
  assign o_watchdog_service = s_reg.wd_pulse;
  assign o_data_req = (s_reg.st == ST_PLOAD);
  assign o_flash_we = s_reg.we;
  assign o_flash_hv = s_reg.hv;
  assign o_page_erase = s_reg.hv && (s_reg.st == ST_EPULSE) && !s_reg.whole;
  assign o_array_erase = s_reg.hv && (s_reg.st == ST_EPULSE) && s_reg.whole;
  assign o_flash_addr = s_reg.addr;
  assign o_flash_data = s_reg.data;
  assign o_erase_refused = s_reg.refused;
  assign o_access_ok = s_reg.access_ok;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_erase_call;
    (s_reg.st == ST_IDLE) && i_erase_start;
  endsequence

  a_mask_during_op: assert property ( // RULE9
    o_busy && s_reg.st != ST_FIN |-> o_irq_mask)
    else $error("interrupts not masked during operation");
  a_mask_restore: assert property ( // RULE9
    s_reg.st == ST_FIN |=> o_irq_mask == $past(s_reg.saved_mask))
    else $error("interrupt mask not restored");
  a_whole_select: assert property ( // RULE4
    s_erase_call and (i_index_addr == BPR_ADDR) |=> s_reg.whole)
    else $error("protect address did not select whole erase");
  a_page_select: assert property ( // RULE5 RULE3
    s_erase_call and (i_index_addr != BPR_ADDR) |=> !s_reg.whole &&
    s_reg.addr == (($past(i_index_addr)) & PAGE_MASK))
    else $error("page erase address wrong");
  a_wd_first: assert property ( // RULE10
    s_erase_call |=>
    s_reg.wd_cnt == 16'(WD_BASE + WD_MUL * 16'($past(i_op_speed_code))))
    else $error("first watchdog count wrong");
  a_addr_next: assert property ( // RULE1
    s_reg.st == ST_PPULSE && tmr_done |=>
    o_index_addr == $past(s_reg.addr) + 16'h1)
    else $error("address not advanced after program");
  a_prot_refuse: assert property ( // RULE12
    s_reg.st == ST_EWAIT && is_prot |=> !o_flash_hv && o_erase_refused)
    else $error("protected erase not refused");
  a_hv_bypass: assert property ( // RULE13
    s_reg.st == ST_EWAIT && s_reg.hv_sync[1] |=> o_flash_hv)
    else $error("test voltage did not bypass protection");
  a_access_open: assert property ( // RULE14
    s_reg.st == ST_EPULSE && tmr_done && s_reg.whole |=> o_access_ok)
    else $error("access not reopened after whole erase");
  a_access_drop: assert property ( // RULE14
    s_reg.sec_sync[1] && !s_reg.sec_q &&
    !(s_reg.st == ST_EPULSE && tmr_done && s_reg.whole) |=> !o_access_ok)
    else $error("access not closed after failed check");
  a_prog_len: assert property ( // RULE16 RULE2
    s_reg.st == ST_PLOAD && s_reg.spd >= 8'h05 |->
    tmr_count == 32'(16'h8 * 16'(s_reg.spd) + 16'h5))
    else $error("program pulse length wrong");
  a_prog_short: assert property ( // RULE6
    s_reg.st == ST_PLOAD && s_reg.spd < 8'h05 |->
    tmr_count == 32'(PROG_CASE1_CYC))
    else $error("slow program pulse length wrong");
  a_erase_len: assert property ( // RULE7 RULE6
    s_reg.st == ST_EWAIT && !is_prot |->
    tmr_count == (32'd4500 * 32'(s_reg.spd)) >> 2)
    else $error("erase pulse length wrong");
  a_erase_window: assert property ( // RULE7
    s_reg.st == ST_EWAIT && !is_prot |->
    (tmr_count << 2) >= 32'(ERASE_MIN_US) * 32'(s_reg.spd) &&
    (tmr_count << 2) <= 32'(ERASE_MAX_US) * 32'(s_reg.spd))
    else $error("erase pulse outside its time window");
  a_wd_reload: assert property ( // RULE17
    o_watchdog_service |-> s_reg.wd_cnt == WD_PERIOD)
    else $error("watchdog not rescheduled");
endmodule

/* verif/fes_flash_model.sv */
// flash array and block-protect register seen by the sequencer
// assumes single-clock write strobes and erase pulses framed by hv
`timescale 1ns/100ps
module fes_flash_model (
  input wire logic i_clk,
  input wire logic i_flash_we,
  input wire logic i_flash_hv,
  input wire logic i_page_erase,
  input wire logic i_array_erase,
  input wire logic [fes_pkg::ADDR_W-1:0] i_flash_addr,
  input wire logic [fes_pkg::DATA_W-1:0] i_flash_data,
  output logic [fes_pkg::DATA_W-1:0] o_block_protect_reg
);
  import fes_pkg::*;
  // unwritten cells read as erased
  logic [7:0] mem [logic [15:0]];
  logic [7:0] bpr = 8'hff;
  logic hv_q = 1'h0, pe_q = 1'h0, ae_q = 1'h0;
  assign o_block_protect_reg = bpr;
  function automatic logic [7:0] rd(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction
  // erased cells change only when the pulse closes; program writes land with the strobe
  // the erase kind drops together with hv, so it is held from the last
  // cycle of the pulse
  always @(posedge i_clk) begin
    hv_q <= i_flash_hv;
    pe_q <= i_page_erase;
    ae_q <= i_array_erase;
    if (i_flash_we === 1'h1) mem[i_flash_addr] = i_flash_data;
    if (hv_q && !i_flash_hv && ae_q) mem.delete();
    if (hv_q && !i_flash_hv && pe_q) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        mem.delete((i_flash_addr & PAGE_MASK) + 16'(i));
      end
    end
  end
endmodule

/* verif/tb_flash_erase_program_sequencer.sv */
// self-checking bench for the flash erase/program sequencer
// assumes fes_pkg, the design and fes_flash_model compile first
`timescale 1ns/100ps
module tb_flash_erase_program_sequencer;
  import fes_pkg::*;
  logic i_clk = 1'h0, i_rst_n = 1'h0, i_erase_start = 1'h0;
  logic i_prog_start = 1'h0, i_irq_mask = 1'h0, i_hv_test = 1'h0;
  logic i_sec_failed = 1'h0;
  logic [15:0] i_index_addr = 16'hc000, i_last_range_address = 16'hc000;
  logic [7:0] i_op_speed_code = 8'h04, i_prog_data = 8'h00;
  logic [7:0] i_block_protect_reg;
  logic o_busy, o_done, o_irq_mask, o_watchdog_service, o_data_req;
  logic o_flash_we, o_flash_hv, o_page_erase, o_array_erase;
  logic o_erase_refused, o_access_ok;
  logic [15:0] o_index_addr, o_flash_addr;
  logic [7:0] o_flash_data;
  logic [7:0] pdata [32];
  int err_total = 0, comparisons = 0;
  int cyc = 0, k = 0, hv_cnt = 0, hv_len = 0, wd_at = -1, t0 = 0;
  fes_sequencer dut (.i_clk, .i_rst_n, .i_erase_start, .i_prog_start,
    .i_index_addr, .i_last_range_address, .i_op_speed_code, .i_prog_data,
    .i_block_protect_reg, .i_irq_mask, .i_hv_test, .i_sec_failed, .o_busy,
    .o_done, .o_index_addr, .o_irq_mask, .o_watchdog_service, .o_data_req,
    .o_flash_we, .o_flash_hv, .o_page_erase, .o_array_erase, .o_flash_addr,
    .o_flash_data, .o_erase_refused, .o_access_ok);
  fes_flash_model flash (.i_clk, .i_flash_we(o_flash_we),
    .i_flash_hv(o_flash_hv), .i_page_erase(o_page_erase),
    .i_array_erase(o_array_erase), .i_flash_addr(o_flash_addr),
    .i_flash_data(o_flash_data), .o_block_protect_reg(i_block_protect_reg));
  always #5 i_clk = ~i_clk;
  // *****************************************************
  // monitors: pulse length, first service, data feed
  // *****************************************************
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (o_watchdog_service === 1'h1 && wd_at < 0) wd_at = cyc;
    if (o_flash_hv === 1'h1) hv_cnt = hv_cnt + 1;
    else if (hv_cnt > 0) begin
      hv_len = hv_cnt;
      hv_cnt = 0;
    end
    if (o_data_req === 1'h1) k = k + 1;
    #1 i_prog_data = pdata[k[4:0]];
  end
  task automatic check(logic [31:0] seen, logic [31:0] exp, string what);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("ERROR %0t %s: got %0h want %0h", $time, what, seen, exp);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset();
    i_rst_n = 1'h0;
    repeat (4) @(posedge i_clk);
    #1 i_rst_n = 1'h1;
  endtask
  task automatic kick(logic er, logic [15:0] a);
    @(posedge i_clk);
    #1 i_index_addr = a;
    i_erase_start = er;
    i_prog_start = !er;
    t0 = cyc + 1;
    wd_at = -1;
    @(posedge i_clk);
    #1 i_erase_start = 1'h0;
    i_prog_start = 1'h0;
  endtask
  task automatic wait_done(int lim, logic m);
    int n;
    for (n = 0; n < lim && o_done !== 1'h1; n++) begin
      @(posedge i_clk);
      #1;
    end
    check(n < lim, 1, "no done");
    check(o_irq_mask, m, "mask at exit");
  endtask
  // program pulse length in bus cycles for a speed code
  function automatic int prog_exp(logic [7:0] spd);
    return (spd < SPD_ROW_MIN) ? int'(PROG_CASE1_CYC) : 8 * spd + 5;
  endfunction
  task automatic prog(logic [7:0] spd, logic [15:0] base, int off, int len);
    logic m;
    m = 1'($urandom);
    for (int i = 0; i < 32; i++) pdata[i] = 8'($urandom);
    i_op_speed_code = spd;
    i_irq_mask = m;
    i_last_range_address = base + 16'(off + len - 1);
    k = off;
    kick(1'h0, base + 16'(off));
    wait_done(len * prog_exp(spd) * 25 + 400, m);
    check(o_index_addr, base + 16'(off + len), "next addr");
    // bus enable phase is free: count whole bus cycles of the pulse
    check((hv_len - 2) / 25 + 1, prog_exp(spd), "prog pulse");
    for (int i = 0; i < 32; i++) begin
      check(flash.rd(base + 16'(i)),
        (i >= off && i < off + len) ? pdata[i] : 8'hff, "row byte");
    end
  endtask
  task automatic erase(logic [15:0] a, logic [7:0] bpr, logic hv, logic rf);
    logic [7:0] spd;
    logic m;
    spd = 8'(4 + $urandom % 29);
    m = 1'($urandom);
    flash.bpr = bpr;
    i_hv_test = hv;
    i_op_speed_code = spd;
    i_irq_mask = m;
    repeat (4) @(posedge i_clk);
    kick(1'h1, a);
    repeat (1) @(posedge i_clk);
    #1 check(o_irq_mask, 1, "mask in erase");
    check(o_erase_refused, rf, "refusal");
    check(o_flash_hv, !rf, "erase voltage");
    if (rf) begin
      wait_done(2000, m);
      return;
    end
    check(o_array_erase, a == BPR_ADDR, "whole erase");
    check(o_page_erase, a != BPR_ADDR, "page erase");
    if (a != BPR_ADDR) begin
      check(o_flash_addr & PAGE_MASK, a & PAGE_MASK, "page");
    end
    for (int n = 0; n < 4000 && wd_at < 0; n++) @(posedge i_clk);
    // the service lands inside the n-th bus cycle after the call
    #1 check((wd_at - t0 - 2) / 25 + 1, 51 + 3 * spd,
      "first service");
    // full erase is too long for the run, so reset ends it mid-pulse
    do_reset();
  endtask
  // *****************************************************
  // main sequence and watchdog
  // *****************************************************
  initial begin
    int off, len;
    void'($urandom(8));
    do_reset();
    check(o_access_ok, 1, "access after reset");
    check(o_busy, 0, "idle after reset");
    prog(8'h05, FLASH_BASE, 0, 1);
    prog(8'h20, FLASH_BASE + 16'h0040, 31, 1);
    prog(8'h04, FLASH_BASE + 16'h0020, 3, 2);
    for (int t = 0; t < 2; t++) begin
      len = 1 + $urandom % 4;
      off = $urandom % (33 - len);
      prog(8'(5 + $urandom % 8), FLASH_BASE + 16'(128 + 64 * t), off, len);
    end
    erase(FLASH_BASE + 16'($urandom % 16'h3e00), 8'hff, 1'h0, 1'h0);
    erase(BPR_ADDR, 8'hff, 1'h0, 1'h0);
    erase(16'he121, 8'h00, 1'h0, 1'h1);
    erase(16'he121, 8'h00, 1'h1, 1'h0);
    erase(BPR_ADDR, 8'h80, 1'h0, 1'h1);
    i_sec_failed = 1'h1;
    repeat (4) @(posedge i_clk);
    #1 check(o_access_ok, 0, "access after failed check");
    summarize();
  end
  initial begin
    #1_000_000;
    check(0, 1, "timeout");
    summarize();
  end
endmodule
